/* hw/cbs_pkg.sv */
// socket event register group: offsets, field positions, reset values, carriers
// assumes a 32-bit memory-mapped host bus and a config port for the base address
package cbs_pkg;

    localparam int FLAG_W = 4;

    // byte offsets inside the socket register page
    localparam logic [11:0] OFS_FLAGS = 12'h000;
    localparam logic [11:0] OFS_ENABLE = 12'h004;
    localparam logic [11:0] OFS_LIVE = 12'h008;
    localparam logic [11:0] OFS_INJECT = 12'h00c;
    localparam logic [11:0] OFS_CONTROL = 12'h010;
    localparam logic [11:0] OFS_RSVD_LO = 12'h014;
    localparam logic [11:0] OFS_RSVD_HI = 12'h01c;
    localparam logic [11:0] OFS_POWER = 12'h020;

    // configuration space offset of the socket base address
    localparam logic [7:0] CFG_OFS_BASE = 8'h10;

    // field positions in the event, enable and live status registers
    localparam int BIT_CARD_STATUS = 0;
    localparam int BIT_DETECT_ONE = 1;
    localparam int BIT_DETECT_TWO = 2;
    localparam int BIT_POWER_CYCLE = 3;
    // position of the card reset pin in the synchronised pin vector
    localparam int BIT_CARD_RESET = 4;
    localparam int PIN_W = 5;

    // values after reset
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
    localparam logic [FLAG_W-1:0] ENABLE_RESET = 4'h0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] POWER_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    // fixed supply capability bits of the live status register
    localparam logic [31:0] LIVE_FIXED = 32'h3000_0000;

    // cycles for the pin synchroniser to fill before edges are trusted
    localparam logic [1:0] SETTLE_DONE = 2'h3;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } cbs_mem_req_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
        logic [31:0] wdata;
    } cbs_cfg_req_type;

    typedef struct packed {
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] enable;
        logic [31:0] control;
        logic [31:0] power_mgmt;
        logic [31:0] base;
        logic [FLAG_W-1:0] live;
        logic in_card_reset;
        logic [1:0] settle;
        logic [31:0] rdata;
        logic rvalid;
        logic [31:0] cfg_rdata;
        logic cfg_rvalid;
        logic irq;
    } cbs_state_type;

endpackage

/* hw/cbs_socket_event_regs.sv */
// socket register group: change flags, enables, live status, inject, control, power
// assumes single-cycle host requests with read data one cycle later; pins are async
`timescale 1ns/1ps
// Notes on behaviour
// - group sits at base from config offset 10h
// - five registers 00h-10h, 14h-1Ch reserved
// - extra power-management register at 20h
// - flags record change only; live register shows levels
// - writing 1 clears a flag, 0 keeps it
// - inject register write-1 sets matching flag
// - host reset clears all flags
// - leaving card reset re-flags still present status
// - enabling with a flag set raises interrupt
// - event bits 31-4 read as zero
// - power cycle status change sets bit 3
// - second detect change sets bit 2
// - first detect change sets bit 1
// - cardbus card: status rise sets bit 0
// - 16-bit card: both status edges set bit 0
// - enables gate interrupt only, never flag setting
// - detect interrupt needs both detect enables set
module cbs_socket_event_regs #(
    parameter int BASE_LSB = 12
) (
    input wire logic clk,                         // system clock, 125 MHz
    input wire logic reset,                       // host bus reset, sync, active high
    input wire cbs_pkg::cbs_mem_req_type mem_req, // host memory request
    output logic [31:0] mem_rdata,                // read data
    output logic mem_rvalid,                      // read data valid pulse
    input wire cbs_pkg::cbs_cfg_req_type cfg_req, // configuration request
    output logic [31:0] cfg_rdata,                // configuration read data
    output logic cfg_rvalid,                      // configuration read valid pulse
    input wire logic card_status_pin,             // card status-change pin, async
    input wire logic detect_one_pin_n,            // first card detect, async, low = in
    input wire logic detect_two_pin_n,            // second card detect, async, low = in
    input wire logic power_cycle_pin,             // power cycle status, async
    input wire logic card_reset_pin,              // card reset level, async
    input wire logic card_is_cardbus,             // card type from identification logic
    output logic csc_irq,                         // status-change interrupt, level
    output logic [31:0] socket_control,           // control register contents
    output logic [31:0] socket_power_management   // power-management register contents
);
    import cbs_pkg::*;

    initial begin
        if (BASE_LSB < 12 || BASE_LSB > 31) begin
            $error("cbs_socket_event_regs: BASE_LSB must be 12..31");
        end
    end

    cbs_state_type st;
    cbs_state_type nxt_st;

    logic [PIN_W-1:0] pins_async;
    logic [PIN_W-1:0] pins_sync;
    logic [31:0] page_mask;
    logic page_hit;
    logic [11:0] ofs;
    logic mem_wr;
    logic mem_rd;
    logic primed;
    logic [FLAG_W-1:0] live_now;
    logic [FLAG_W-1:0] hw_set;
    logic [FLAG_W-1:0] exit_set;
    logic [FLAG_W-1:0] clr_vec;
    logic [FLAG_W-1:0] force_vec;
    logic [FLAG_W-1:0] gated;
    logic status_rise;
    logic status_fall;
    logic card_reset_exit;

    assign pins_async = {card_reset_pin, power_cycle_pin, detect_two_pin_n,
                         detect_one_pin_n, card_status_pin};

    cbs_sync2 #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .din(pins_async),
        .dout(pins_sync)
    );

    // byte-lane merge for plain read/write registers
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // interrupt gating; detect pair only counts when both enables are set
    function automatic logic [FLAG_W-1:0] gate_flags(input logic [FLAG_W-1:0] flags,
                                                     input logic [FLAG_W-1:0] en);
        logic [FLAG_W-1:0] res;
        logic detect_en;
        detect_en = en[BIT_DETECT_ONE] & en[BIT_DETECT_TWO];
        res = '0;
        res[BIT_CARD_STATUS] = flags[BIT_CARD_STATUS] & en[BIT_CARD_STATUS];
        res[BIT_DETECT_ONE] = flags[BIT_DETECT_ONE] & detect_en;
        res[BIT_DETECT_TWO] = flags[BIT_DETECT_TWO] & detect_en;
        res[BIT_POWER_CYCLE] = flags[BIT_POWER_CYCLE] & en[BIT_POWER_CYCLE];
        return res;
    endfunction

    // decode within the page located by the base register
    assign page_mask = ~((32'h1 << BASE_LSB) - 32'h1);
    assign page_hit = ((mem_req.addr & page_mask) == (st.base & page_mask)) &&
                      (((mem_req.addr & ~page_mask) >> 12) == 32'h0);
    assign ofs = {mem_req.addr[11:2], 2'b00};
    assign mem_wr = mem_req.valid && mem_req.write && page_hit;
    assign mem_rd = mem_req.valid && !mem_req.write && page_hit;

    assign primed = (st.settle == SETTLE_DONE);
    assign live_now = pins_sync[FLAG_W-1:0];
    assign status_rise = live_now[BIT_CARD_STATUS] && !st.live[BIT_CARD_STATUS];
    assign status_fall = !live_now[BIT_CARD_STATUS] && st.live[BIT_CARD_STATUS];
    assign card_reset_exit = primed && st.in_card_reset && !pins_sync[BIT_CARD_RESET];

    // hardware change detection; flags note a change, not the level
    always_comb begin
        hw_set = '0;
        if (primed) begin
            hw_set[BIT_POWER_CYCLE] = live_now[BIT_POWER_CYCLE] ^
                                      st.live[BIT_POWER_CYCLE];
            hw_set[BIT_DETECT_TWO] = live_now[BIT_DETECT_TWO] ^
                                     st.live[BIT_DETECT_TWO];
            hw_set[BIT_DETECT_ONE] = live_now[BIT_DETECT_ONE] ^
                                     st.live[BIT_DETECT_ONE];
            if (card_is_cardbus) begin
                hw_set[BIT_CARD_STATUS] = status_rise;
            end else begin
                hw_set[BIT_CARD_STATUS] = status_rise || status_fall;
            end
        end
    end

    // status still present when the card leaves reset is flagged again
    always_comb begin
        exit_set = '0;
        if (card_reset_exit) begin
            exit_set[BIT_CARD_STATUS] = live_now[BIT_CARD_STATUS];
            exit_set[BIT_DETECT_ONE] = !live_now[BIT_DETECT_ONE];
            exit_set[BIT_DETECT_TWO] = !live_now[BIT_DETECT_TWO];
        end
    end

    assign clr_vec = (mem_wr && ofs == OFS_FLAGS && mem_req.be[0]) ?
                     mem_req.wdata[FLAG_W-1:0] : '0;
    assign force_vec = (mem_wr && ofs == OFS_INJECT && mem_req.be[0]) ?
                       mem_req.wdata[FLAG_W-1:0] : '0;
    assign gated = gate_flags(st.flags, st.enable);

    always_comb begin
        nxt_st = st;
        nxt_st.rvalid = 1'b0;
        nxt_st.cfg_rvalid = 1'b0;
        nxt_st.live = live_now;
        nxt_st.in_card_reset = pins_sync[BIT_CARD_RESET];
        if (!primed) begin
            nxt_st.settle = st.settle + 2'h1;
        end

        // hardware and inject sets win over a same-cycle clear
        nxt_st.flags = (st.flags & ~clr_vec) | hw_set | exit_set | force_vec;

        if (mem_wr) begin
            case (ofs)
                OFS_ENABLE: begin
                    if (mem_req.be[0]) begin
                        nxt_st.enable = mem_req.wdata[FLAG_W-1:0];
                    end
                end
                OFS_CONTROL: begin
                    nxt_st.control = merge_bytes(st.control, mem_req.wdata,
                                                 mem_req.be);
                end
                OFS_POWER: begin
                    nxt_st.power_mgmt = merge_bytes(st.power_mgmt, mem_req.wdata,
                                                    mem_req.be);
                end
                default: begin
                end
            endcase
        end

        if (mem_rd) begin
            nxt_st.rvalid = 1'b1;
            case (ofs)
                OFS_FLAGS: nxt_st.rdata = {28'h0, st.flags};
                OFS_ENABLE: nxt_st.rdata = {28'h0, st.enable};
                OFS_LIVE: nxt_st.rdata = LIVE_FIXED | {28'h0, st.live};
                OFS_CONTROL: nxt_st.rdata = st.control;
                OFS_POWER: nxt_st.rdata = st.power_mgmt;
                default: nxt_st.rdata = 32'h0;
            endcase
        end

        if (cfg_req.valid) begin
            if (cfg_req.write) begin
                if (cfg_req.offset == CFG_OFS_BASE) begin
                    nxt_st.base = cfg_req.wdata & page_mask;
                end
            end else begin
                nxt_st.cfg_rvalid = 1'b1;
                if (cfg_req.offset == CFG_OFS_BASE) begin
                    nxt_st.cfg_rdata = st.base & page_mask;
                end else begin
                    nxt_st.cfg_rdata = 32'h0;
                end
            end
        end

        // level request held while any enabled flag stays set
        nxt_st.irq = |gated;

        if (reset) begin
            nxt_st.flags = FLAGS_RESET;
            nxt_st.enable = ENABLE_RESET;
            nxt_st.control = CONTROL_RESET;
            nxt_st.power_mgmt = POWER_RESET;
            nxt_st.base = BASE_RESET;
            nxt_st.live = '0;
            nxt_st.in_card_reset = 1'b0;
            nxt_st.settle = 2'h0;
            nxt_st.rdata = 32'h0;
            nxt_st.rvalid = 1'b0;
            nxt_st.cfg_rdata = 32'h0;
            nxt_st.cfg_rvalid = 1'b0;
            nxt_st.irq = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st <= nxt_st;
    end

    assign mem_rdata = st.rdata;
    assign mem_rvalid = st.rvalid;
    assign cfg_rdata = st.cfg_rdata;
    assign cfg_rvalid = st.cfg_rvalid;
    assign csc_irq = st.irq;
    assign socket_control = st.control;
    assign socket_power_management = st.power_mgmt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence power_change_seq;
        primed && (live_now[BIT_POWER_CYCLE] != st.live[BIT_POWER_CYCLE]);
    endsequence

    sequence status_fall_16bit_seq;
        primed && !card_is_cardbus && status_fall;
    endsequence

    sequence flags_read_seq;
        mem_rd && ofs == OFS_FLAGS;
    endsequence

    sequence card_reset_exit_seq;
        card_reset_exit && live_now[BIT_CARD_STATUS];
    endsequence

    chk_reserved_zero: assert property (
        flags_read_seq |=> mem_rvalid && mem_rdata[31:4] == 28'h0)
        else $error("event register upper bits not zero");

    chk_clear_only_write: assert property (
        (($past(st.flags) & ~st.flags & ~$past(clr_vec)) == 4'h0) || $past(reset))
        else $error("flag dropped without a write-one clear");

    chk_clear_takes: assert property (
        (clr_vec != 4'h0) && ((hw_set | exit_set | force_vec) == 4'h0)
        |=> (st.flags & $past(clr_vec)) == 4'h0)
        else $error("write-one clear did not clear flag");

    chk_inject_sets: assert property (
        (force_vec != 4'h0) |=> ((st.flags & $past(force_vec)) == $past(force_vec)))
        else $error("inject write did not set flag");

    chk_reset_clears: assert property ($past(reset) |-> st.flags == 4'h0 && !csc_irq)
        else $error("flags not cleared by reset");

    chk_power_change: assert property (power_change_seq |=> st.flags[BIT_POWER_CYCLE])
        else $error("power cycle change not flagged");

    chk_status_both_edges: assert property (
        status_fall_16bit_seq |=> st.flags[BIT_CARD_STATUS])
        else $error("16-bit card status fall not flagged");

    chk_cardbus_fall_ignored: assert property (
        primed && card_is_cardbus && status_fall && !st.flags[BIT_CARD_STATUS] &&
        !force_vec[BIT_CARD_STATUS] && !exit_set[BIT_CARD_STATUS]
        |=> !st.flags[BIT_CARD_STATUS])
        else $error("cardbus status fall set flag");

    chk_reset_exit_flag: assert property (
        card_reset_exit_seq |=> st.flags[BIT_CARD_STATUS])
        else $error("status present at card reset exit not flagged");

    chk_irq_follows: assert property (
        !$past(reset) |-> csc_irq == |$past(gated))
        else $error("interrupt does not follow enabled flags");

    chk_detect_pair: assert property (
        (st.enable[2:1] != 2'b11) && !st.enable[0] && !st.enable[3] |=> !csc_irq)
        else $error("detect interrupt without both enables");

    chk_mask_free_set: assert property (
        (hw_set != 4'h0) |=> ((st.flags & $past(hw_set)) == $past(hw_set)))
        else $error("hardware event lost");

    chk_set_wins: assert property (
        ((clr_vec & hw_set) != 4'h0) |=>
        ((st.flags & $past(clr_vec) & $past(hw_set)) == ($past(clr_vec) & $past(hw_set))))
        else $error("same-cycle clear beat hardware set");

    chk_read_pulse: assert property (
        !$past(reset) |-> mem_rvalid == $past(mem_rd))
        else $error("read answer pulse wrong");

    chk_off_page_silent: assert property (
        (mem_req.valid && !page_hit) |=> !mem_rvalid)
        else $error("request outside the page answered");

    chk_base_locate: assert property (
        (cfg_req.valid && cfg_req.write && cfg_req.offset == CFG_OFS_BASE)
        |=> st.base == ($past(cfg_req.wdata) & page_mask))
        else $error("base address not taken");

    chk_live_read: assert property (
        (mem_rd && ofs == OFS_LIVE && !$past(reset))
        |=> mem_rdata == (LIVE_FIXED | {28'h0, $past(live_now, 2)}))
        else $error("live status read wrong");

endmodule

/* hw/cbs_sync2.sv */
// two-flop synchroniser for a vector of independent level signals
// assumes each bit is a slow level; no bus coherency across bits
`timescale 1ns/1ps
module cbs_sync2 #(
    parameter int WIDTH = 5
) (
    input wire logic clk,              // system clock
    input wire logic reset,            // synchronous reset, active high
    input wire logic [WIDTH-1:0] din,  // asynchronous levels
    output logic [WIDTH-1:0] dout      // synchronised levels
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("cbs_sync2: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

/* verification/cbs_socket_event_regs_test.sv */
// self-checking bench for the socket event register group with a flag model
// assumes the socket model drives the pins and the bench owns both host ports
`timescale 1ns/1ps
module cbs_socket_event_regs_test;
    import cbs_pkg::*;
    localparam int LIMIT = 20000;
    logic clk, reset, mem_rvalid, cfg_rvalid, csc_irq, card_is_cardbus, slow;
    cbs_mem_req_type mem_req;
    cbs_cfg_req_type cfg_req;
    logic [31:0] mem_rdata, cfg_rdata, socket_control, socket_power_management, seed, base;
    logic card_status_pin, detect_one_pin_n, detect_two_pin_n, power_cycle_pin, card_reset_pin;
    logic [4:0] want, m_pins;
    logic [3:0] m_flags, m_en;
    logic [31:0] m_reg [2];
    int fails, num_checks, cyc;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    cbs_socket_event_regs #(.BASE_LSB(12)) i_cbs_socket_event_regs (.clk(clk), .reset(reset),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .card_status_pin(card_status_pin),
        .detect_one_pin_n(detect_one_pin_n), .detect_two_pin_n(detect_two_pin_n),
        .power_cycle_pin(power_cycle_pin), .card_reset_pin(card_reset_pin),
        .card_is_cardbus(card_is_cardbus), .csc_irq(csc_irq), .socket_control(socket_control),
        .socket_power_management(socket_power_management));
    cbs_socket_model i_cbs_socket_model (.clk(clk), .want(want), .slow(slow),
        .card_status_pin(card_status_pin), .detect_one_pin_n(detect_one_pin_n),
        .detect_two_pin_n(detect_two_pin_n), .power_cycle_pin(power_cycle_pin),
        .card_reset_pin(card_reset_pin));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic m_irq();
        return (m_flags[0] & m_en[0]) | (m_flags[3] & m_en[3])
            | ((m_flags[1] | m_flags[2]) & m_en[1] & m_en[2]);
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    // one request, held for its taking edge; read answer sampled just after it
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd, output logic rv);
        @(posedge clk);
        mem_req <= '{1'b1, wr, addr, wd, be};
        @(posedge clk);
        mem_req.valid <= 1'b0;
        #1;
        rv = mem_rvalid;
        rd = mem_rdata;
    endtask

    task automatic cfg_op(input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        cfg_req <= '{1'b1, wr, CFG_OFS_BASE, wd};
        @(posedge clk);
        cfg_req.valid <= 1'b0;
        #1;
        rd = cfg_rdata;
        if (!wr) cmp_bit("cfg_rvalid", 1'b1, cfg_rvalid);
    endtask

    task automatic wr(input logic [11:0] ofs, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] rd;
        logic rv;
        bus(1'b1, base | ofs, d, be, rd, rv);
        if (ofs == OFS_FLAGS) m_flags = m_flags & ~d[3:0];
        if (ofs == OFS_INJECT) m_flags = m_flags | d[3:0];
    endtask

    task automatic read_chk(input logic [11:0] ofs, input logic [31:0] exp, input string name);
        logic [31:0] rd;
        logic rv;
        bus(1'b0, base | ofs, 32'h0, 4'hf, rd, rv);
        cmp_bit("mem_rvalid", 1'b1, rv);
        cmp_word(name, exp, rd);
    endtask

    task automatic check_state();
        read_chk(OFS_FLAGS, {28'h0, m_flags}, "flags");
        read_chk(OFS_LIVE, LIVE_FIXED | {28'h0, m_pins[3:0]}, "live");
        cmp_bit("csc_irq", m_irq(), csc_irq);
    endtask

    // model the change flags for a new pin vector, then let it settle
    task automatic set_pins(input logic [4:0] v);
        if (v[3] != m_pins[3]) m_flags[3] = 1'b1;
        if (v[2] != m_pins[2]) m_flags[2] = 1'b1;
        if (v[1] != m_pins[1]) m_flags[1] = 1'b1;
        if (card_is_cardbus ? (v[0] & ~m_pins[0]) : (v[0] != m_pins[0])) m_flags[0] = 1'b1;
        if (m_pins[4] && !v[4]) m_flags = m_flags | {~v[2], ~v[2], ~v[1], v[0]} & 4'h7;
        m_pins = v;
        @(posedge clk);
        want <= v;
        repeat (9) @(posedge clk);
        check_state();
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] rd, d;
        logic rv;
        logic [11:0] ofs;
        logic [3:0] be;
        logic [3:0] ens [6];
        logic [11:0] zero_ofs [8];
        ens = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hf};
        zero_ofs = '{OFS_FLAGS, OFS_ENABLE, OFS_INJECT, OFS_CONTROL, OFS_RSVD_LO, 12'h018,
            OFS_RSVD_HI, 12'h024};
        reset = 1'b1;
        mem_req = '0;
        cfg_req = '0;
        want = 5'h06;
        slow = 1'b0;
        card_is_cardbus = 1'b1;
        m_pins = 5'h06;
        m_flags = 4'h0;
        m_en = 4'h0;
        m_reg = '{32'h0, 32'h0};
        fails = 0;
        num_checks = 0;
        cyc = 0;
        seed = 32'd96740;
        base = 32'h0;
        repeat (12) @(posedge clk);
        for (int pass = 0; pass < 2; pass++) begin
            reset <= 1'b0;
            repeat (4) @(posedge clk);
            base = 32'h4000_0000;
            cfg_op(1'b1, base | 32'h0abc, rd);
            cfg_op(1'b0, 32'h0, rd);
            cmp_word("base", base, rd);
            foreach (zero_ofs[i]) read_chk(zero_ofs[i], 32'h0, "reset value");
            read_chk(OFS_POWER, m_reg[1], "power");
            if (pass == 1) break;
            bus(1'b0, base + 32'h0000_1000, 32'h0, 4'hf, rd, rv);
            cmp_bit("off page rvalid", 1'b0, rv);
            for (int i = 3; i >= 0; i--) set_pins(m_pins ^ (5'h01 << i));
            wr(OFS_FLAGS, 32'h0, 4'hf);
            check_state();
            wr(OFS_FLAGS, 32'hffff_ffff, 4'hf);
            check_state();
            set_pins(m_pins ^ 5'h01);
            card_is_cardbus <= 1'b0;
            slow = 1'b1;
            set_pins(m_pins ^ 5'h01);
            wr(OFS_FLAGS, 32'h1, 4'h1);
            set_pins(m_pins ^ 5'h01);
            slow = 1'b0;
            wr(OFS_INJECT, 32'hffff_ffff, 4'hf);
            read_chk(OFS_INJECT, 32'h0, "inject");
            check_state();
            foreach (ens[i]) begin
                wr(OFS_ENABLE, {28'hfff_fff0, ens[i]}, 4'hf);
                m_en = ens[i];
                read_chk(OFS_ENABLE, {28'h0, m_en}, "enable");
                check_state();
            end
            for (int i = 0; i < 4; i++) begin
                wr(OFS_FLAGS, 32'h1 << i, 4'h1);
                check_state();
            end
            set_pins(m_pins | 5'h10);
            set_pins({1'b1, m_pins[3], 2'b00, 1'b1});
            wr(OFS_FLAGS, 32'hf, 4'h1);
            check_state();
            set_pins({1'b0, m_pins[3:0]});
            // clear lands in the cycle the power change is flagged
            @(posedge clk);
            want <= m_pins ^ 5'h08;
            m_pins = m_pins ^ 5'h08;
            repeat (2) @(posedge clk);
            wr(OFS_FLAGS, 32'h8, 4'h1);
            m_flags[3] = 1'b1;
            check_state();
            for (int k = 0; k < 8; k++) begin
                seed = xs(seed);
                d = seed;
                seed = xs(seed);
                be = seed[3:0];
                ofs = k[0] ? OFS_POWER : OFS_CONTROL;
                wr(ofs, d, be);
                for (int b = 0; b < 4; b++) if (be[b]) m_reg[k % 2][8*b +: 8] = d[8*b +: 8];
                read_chk(ofs, m_reg[k % 2], "control or power");
                cmp_word("control port", m_reg[0], socket_control);
                cmp_word("power port", m_reg[1], socket_power_management);
            end
            wr(OFS_INJECT, 32'hf, 4'h1);
            @(posedge clk);
            reset <= 1'b1;
            repeat (3) @(posedge clk);
            m_flags = 4'h0;
            m_en = 4'h0;
            m_reg = '{32'h0, 32'h0};
            base = 32'h0;
        end
        check_state();
        give_verdict();
    end
endmodule

/* verification/cbs_socket_model.sv */
// card socket side: drives the socket pins at the levels the bench asks for
// assumes the bench changes its request just after a clock edge
`timescale 1ns/1ps
module cbs_socket_model (
    input wire logic clk,            // system clock
    input wire logic [4:0] want,     // {card reset, power, detect two, detect one, status}
    input wire logic slow,           // hold pins one extra cycle before following
    output logic card_status_pin,    // card status-change level
    output logic detect_one_pin_n,   // first detect, low = card in
    output logic detect_two_pin_n,   // second detect, low = card in
    output logic power_cycle_pin,    // power cycle status
    output logic card_reset_pin      // card held in reset
);
    logic [4:0] lag;

    initial begin
        lag = 5'h06;
        {card_reset_pin, power_cycle_pin, detect_two_pin_n, detect_one_pin_n,
            card_status_pin} = 5'h06;
    end

    // pins move a clean level at a time, like a seated card
    always @(posedge clk) begin
        lag <= want;
        {card_reset_pin, power_cycle_pin, detect_two_pin_n, detect_one_pin_n,
            card_status_pin} <= slow ? lag : want;
    end
endmodule
